// [hw/rsc_reset_shutdown.sv]
// reset and shutdown sequencer: reset entry/exit, stop and shutdown modes
// How it works
// R1: shutdown after stop instruction, then regulator off
// R2: shutdown keeps core, memory, peripherals unpowered
// R3: only pin or power-on reset wakes
// R4: reset halts core instruction execution
// R5: registers reset except power-on-only bits
// R6: reset disables interrupts and timers
// R7: reset leaves data ram unchanged
// R8: port latches one, ports open-drain
// R9: weak pull-ups on during and after reset
// R10: monitor or power-on reset drives pin low
// R11: leaving reset clears pc to zero
// R12: system clock defaults to low-power oscillator
// R13: watchdog enabled, clocked from low-frequency oscillator
// R14: stop with flag clear stops clocks until reset
// R15: reset release synchronous to system clock
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_shutdown
   import rsc_pkg::*;
(
   input wire logic clk,                  // system clock
   input wire logic rst,                  // synchronous active-high reset
   input wire logic pin_reset_n,          // external reset pin level, async
   input wire logic por_event,            // power-on reset detector, async
   input wire logic supply_mon_event,     // supply monitor trip, async
   input wire logic other_reset,          // internal resets: watchdog etc
   input wire logic stop_bit_set,         // stop bit written this cycle
   input wire logic instr_done,           // setting instruction completed
   input wire logic stop_config_flag,     // shutdown selected when set
   output logic reset_pin_drive_low,      // output enable pulling pin low
   output logic reset_pin_out,            // pin output level, always low
   output rsc_ctrl_type ctrl,             // reset controls to the chip
   output logic por_only_clear,           // clears power-on-only bits
   output rsc_pins_type pins,             // forced pin configuration
   output rsc_clkcfg_type clkcfg,         // clock and watchdog defaults
   output logic pc_load,                  // pulse: load program counter
   output logic [15:0] pc_value,          // program counter load value
   output logic osc_run,                  // internal oscillator enable
   output logic periph_clk_en,            // digital peripheral clocks
   output logic regulator_on,             // core regulator enable
   output logic core_power_on             // power to core, memory, periphs
);

   // ==========================================================
   // input synchronisers, two flops each
   logic [2:0] sync1; // first stage, read only by sync2
   logic [2:0] sync2; // second stage, safe to use
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {~pin_reset_n, por_event, supply_mon_event};
         sync2 <= sync1;
      end
   end

   wire pin_rst = sync2[2];            // external pin reset
   wire por_rst = sync2[1];            // power-on reset
   wire mon_rst = sync2[0];            // supply monitor reset
   // only pin or power-on wake from shutdown; a supply monitor trip
   // still reaches mon_rst there and is simply left out of wake_src
   wire wake_src = pin_rst | por_rst;                       // [R3]
   wire any_src = pin_rst | por_rst | mon_rst | other_reset;
   wire drive_src = por_rst | mon_rst;                      // [R10]

   // ==========================================================
   // state machine
   rsc_state_type state;
   rsc_state_type next_state;
   logic [RSC_CNT_W-1:0] hold_cnt;     // release hold counter
   logic [RSC_CNT_W-1:0] next_hold_cnt;
   logic drive_latch;                  // pin pull-down request held
   logic next_drive_latch;
   logic por_seen;                     // power-on part of this reset

   wire stop_req = stop_bit_set & instr_done;  // act after instruction

   // next-state decode
   always_comb begin
      next_state = state;
      next_hold_cnt = hold_cnt;
      case (state)
         RSC_ST_RESET: begin
            // wait until every source is gone
            next_hold_cnt = '0;
            if (!any_src) begin
               next_state = RSC_ST_RELEASE;
            end
         end
         RSC_ST_RELEASE: begin
            if (any_src) begin
               next_state = RSC_ST_RESET;
            end else if (hold_cnt == RSC_CNT_W'(RSC_HOLD_CYC - 1)) begin
               next_state = RSC_ST_RUN;  // release on a clock edge [R15]
            end else begin
               next_hold_cnt = hold_cnt + RSC_CNT_W'(1);
            end
         end
         RSC_ST_RUN: begin
            if (any_src) begin
               next_state = RSC_ST_RESET;
            end else if (stop_req && stop_config_flag) begin
               next_state = RSC_ST_SHUTDOWN;  // [R1]
            end else if (stop_req) begin
               next_state = RSC_ST_STOP;      // [R14]
            end
         end
         RSC_ST_STOP: begin
            // any reset ends stop mode
            if (any_src) begin
               next_state = RSC_ST_RESET;     // [R14]
            end
         end
         RSC_ST_SHUTDOWN: begin
            // monitor and internal resets cannot wake
            if (wake_src) begin
               next_state = RSC_ST_RESET;     // [R3]
            end
         end
         default: begin
            next_state = RSC_ST_RESET;
         end
      endcase
   end

   // pull-down on the pin held until reset exits
   always_comb begin
      next_drive_latch = drive_latch;
      if (next_state == RSC_ST_RUN || next_state == RSC_ST_STOP) begin
         next_drive_latch = 1'b0;
      end else if (drive_src && (next_state == RSC_ST_RESET)) begin
         // a monitor trip while shut down is no reset: it must not arm
         // the pull-down for a later pin wake
         next_drive_latch = 1'b1;                            // [R10]
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= RSC_ST_RESET;
         hold_cnt <= '0;
         drive_latch <= 1'b1;  // treat chip reset as power-on
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
         drive_latch <= next_drive_latch;
      end
   end

   // power-on seen flag, cleared once the sequence runs
   always_ff @(posedge clk) begin
      if (rst) begin
         por_seen <= 1'b1;
      end else if (por_rst) begin
         por_seen <= 1'b1;
      end else if (state == RSC_ST_RUN) begin
         por_seen <= 1'b0;
      end
   end

   // ==========================================================
   // output decode
   wire in_reset = (next_state == RSC_ST_RESET) || (next_state == RSC_ST_RELEASE);
   wire exit_now = (state == RSC_ST_RELEASE) && (next_state == RSC_ST_RUN);
   wire powered = (next_state != RSC_ST_SHUTDOWN);
   wire clocks = (next_state == RSC_ST_RUN) || in_reset;

   rsc_ctrl_type next_ctrl;
   rsc_pins_type next_pins;
   always_comb begin
      next_ctrl.core_halt = in_reset | ~clocks | ~powered;   // [R4]
      next_ctrl.regs_reset = in_reset;                       // [R5]
      next_ctrl.irq_disable = in_reset;                      // [R6]
      next_ctrl.timer_disable = in_reset;                    // [R6]
      // ram only blocked from writes, never cleared
      next_ctrl.ram_hold = in_reset;                         // [R7]
      next_pins = pins;
      if (in_reset) begin
         next_pins.latch = RSC_LATCH_RST;                    // [R8]
         next_pins.open_drain = '1;                          // [R8]
      end
      // pull-ups stay on afterwards; the enable is held at one in every state
      next_pins.weak_pullup_en = 1'b1;                       // [R9]
   end

   // registered outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= '1;
         por_only_clear <= 1'b1;
         pins <= {RSC_LATCH_RST, {RSC_PORT_W{1'b1}}, 1'b1};
         reset_pin_drive_low <= 1'b1;
         pc_load <= 1'b0;
         osc_run <= 1'b1;
         periph_clk_en <= 1'b1;
         regulator_on <= 1'b1;
         core_power_on <= 1'b1;
      end else begin
         ctrl <= next_ctrl;
         por_only_clear <= in_reset & (por_seen | por_rst);  // [R5]
         pins <= next_pins;
         reset_pin_drive_low <= in_reset & next_drive_latch; // [R10]
         pc_load <= exit_now;                                // [R11]
         osc_run <= clocks;                                  // [R14]
         periph_clk_en <= clocks;                            // [R14]
         regulator_on <= powered;                            // [R1]
         core_power_on <= powered;                           // [R2]
      end
   end

   // constant pin level; only the enable moves
   always_ff @(posedge clk) begin
      reset_pin_out <= 1'b0;
   end

   // clock defaults, loaded during reset and held
   always_ff @(posedge clk) begin
      if (rst) begin
         clkcfg <= {RSC_CLK_LPOSC, 1'b1, RSC_WDT_CLK_LFO};
         pc_value <= RSC_PC_RST;
      end else if (in_reset) begin
         clkcfg.sysclk_sel <= RSC_CLK_LPOSC;                 // [R12]
         clkcfg.wdt_enable <= 1'b1;                          // [R13]
         clkcfg.wdt_clk_sel <= RSC_WDT_CLK_LFO;              // [R13]
         pc_value <= RSC_PC_RST;                             // [R11]
      end
   end

   // ==========================================================
   // assertions
   a_shutdown_unpowered: assert property (@(posedge clk) disable iff (rst) // [R2]
      (state == RSC_ST_SHUTDOWN) |-> !core_power_on && !regulator_on)
      else $error("power on during shutdown");

   a_shutdown_entry: assert property (@(posedge clk) disable iff (rst) // [R1]
      (state == RSC_ST_RUN && !any_src && stop_req && stop_config_flag)
      |=> (state == RSC_ST_SHUTDOWN) ##0 !regulator_on)
      else $error("shutdown not entered");

   a_shutdown_wake: assert property (@(posedge clk) disable iff (rst) // [R3]
      (state == RSC_ST_SHUTDOWN && !wake_src) |=> (state == RSC_ST_SHUTDOWN))
      else $error("shutdown left without wake source");

   a_reset_halts: assert property (@(posedge clk) disable iff (rst) // [R4]
      (state == RSC_ST_RESET) |-> ctrl.core_halt && ctrl.irq_disable)
      else $error("core running in reset");

   a_ports_forced: assert property (@(posedge clk) disable iff (rst) // [R8]
      (state == RSC_ST_RESET) |-> (pins.latch == RSC_LATCH_RST)
      && (&pins.open_drain) && pins.weak_pullup_en)
      else $error("ports not forced");

   a_pin_driven: assert property (@(posedge clk) disable iff (rst) // [R10]
      (state == RSC_ST_RUN && mon_rst) |=> ##1 reset_pin_drive_low)
      else $error("reset pin not driven");

   a_pc_cleared: assert property (@(posedge clk) disable iff (rst) // [R11]
      $rose(state == RSC_ST_RUN) |-> pc_load && (pc_value == RSC_PC_RST))
      else $error("pc not loaded at exit");

   a_clk_defaults: assert property (@(posedge clk) disable iff (rst) // [R13]
      pc_load |-> clkcfg.wdt_enable && (clkcfg.wdt_clk_sel == RSC_WDT_CLK_LFO)
      && (clkcfg.sysclk_sel == RSC_CLK_LPOSC))
      else $error("clock defaults wrong");

   a_stop_clocks: assert property (@(posedge clk) disable iff (rst) // [R14]
      (state == RSC_ST_STOP) |-> !osc_run && regulator_on)
      else $error("clocks running in stop");

endmodule : rsc_reset_shutdown
`default_nettype wire

// [include/rsc_pkg.sv]
// package of constants and carrier types for reset and shutdown control
package rsc_pkg;

   // ==========================================================
   // widths and reset values
   localparam int RSC_PORT_W = 18;               // number of port pins
   localparam logic [RSC_PORT_W-1:0] RSC_LATCH_RST = 18'h3_FFFF; // all latches high
   localparam logic [15:0] RSC_PC_RST = 16'h0000; // fetch start address
   localparam logic [1:0] RSC_CLK_LPOSC = 2'h0;  // internal low-power oscillator
   localparam logic [1:0] RSC_WDT_CLK_LFO = 2'h1; // low-frequency oscillator

   // ==========================================================
   // timing: reset hold after source release
   localparam int RSC_HOLD_NS = 100;             // least hold time, ns
   localparam int RSC_CLK_PERIOD_NS = 5;         // 200 MHz clock
   localparam int RSC_HOLD_CYC =
      (RSC_HOLD_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
   localparam int RSC_CNT_W = 8;                 // hold counter width

   // ==========================================================
   // sequencer states, gray along the usual path
   typedef enum logic [2:0] {
      RSC_ST_RESET = 3'b000,   // reset asserted
      RSC_ST_RELEASE = 3'b001, // hold counting before release
      RSC_ST_RUN = 3'b011,     // normal operation
      RSC_ST_STOP = 3'b010,    // regulator on, clocks stopped
      RSC_ST_SHUTDOWN = 3'b110 // regulator off
   } rsc_state_type;

   // reset-time controls that go to the rest of the chip
   typedef struct packed {
      logic core_halt;        // core may not execute
      logic regs_reset;       // module registers load reset values
      logic irq_disable;      // all interrupts off
      logic timer_disable;    // all timers off
      logic ram_hold;         // ram writes blocked, contents kept
   } rsc_ctrl_type;

   // pin configuration forced by reset
   typedef struct packed {
      logic [RSC_PORT_W-1:0] latch;      // port output latches
      logic [RSC_PORT_W-1:0] open_drain; // 1 = open-drain mode
      logic weak_pullup_en;              // global weak pull-up enable
   } rsc_pins_type;

   // clock and watchdog defaults
   typedef struct packed {
      logic [1:0] sysclk_sel;   // system clock source
      logic wdt_enable;         // watchdog enable
      logic [1:0] wdt_clk_sel;  // watchdog clock source
   } rsc_clkcfg_type;

endpackage : rsc_pkg

// [sim/reset_and_shutdown_control_bench.sv]
// self-checking testbench for the reset and shutdown sequencer
`timescale 1ns/10ps
`default_nettype none

module reset_and_shutdown_control_bench;
   import rsc_pkg::*;
   // ==========================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic press_pin = 1'b0;
   logic trip_por = 1'b0;
   logic trip_mon = 1'b0;
   logic other_reset = 1'b0;
   logic stop_bit_set = 1'b0;
   logic instr_done = 1'b0;
   logic stop_config_flag = 1'b0;
   logic pin_reset_n, por_event, supply_mon_event, pin_level;
   logic drive_low, pin_out, por_only_clear, pc_load;
   logic osc_run, periph_clk_en, regulator_on, core_power_on;
   logic [15:0] pc_value;
   rsc_ctrl_type ctrl;
   rsc_pins_type pins;
   rsc_clkcfg_type clkcfg;
   int failures = 0;
   int n_checks = 0;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // ==========================================
   // design and far side
   rsc_reset_shutdown dut (.clk(clk), .rst(rst), .pin_reset_n(pin_reset_n),
      .por_event(por_event), .supply_mon_event(supply_mon_event),
      .other_reset(other_reset), .stop_bit_set(stop_bit_set),
      .instr_done(instr_done), .stop_config_flag(stop_config_flag),
      .reset_pin_drive_low(drive_low), .reset_pin_out(pin_out), .ctrl(ctrl),
      .por_only_clear(por_only_clear), .pins(pins), .clkcfg(clkcfg),
      .pc_load(pc_load), .pc_value(pc_value), .osc_run(osc_run),
      .periph_clk_en(periph_clk_en), .regulator_on(regulator_on),
      .core_power_on(core_power_on));
   rsc_reset_source_model far (.press_pin(press_pin), .trip_por(trip_por),
      .trip_mon(trip_mon), .drive_low(drive_low), .pin_out(pin_out),
      .pin_reset_n(pin_reset_n), .por_event(por_event),
      .supply_mon_event(supply_mon_event), .pin_level(pin_level));

   // ==========================================
   // shared helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // the controls, port pins and pin drive that the reset state forces, looked at mid-reset
   task automatic chk_reset(input logic drv, input logic poc);
      check(ctrl, 5'h1F);
      check(por_only_clear, poc);
      check(pins, {RSC_LATCH_RST, {RSC_PORT_W{1'b1}}, 1'b1});
      check(drive_low, drv);
      check(pin_level, !(drv || press_pin));
   endtask : chk_reset

   // bounded wait for the pc load pulse, then the run-state defaults
   task automatic wait_run(input int min_cyc);
      int n;
      n = 0;
      while (pc_load !== 1'b1 && n < 80) begin
         @(negedge clk);
         n++;
      end
      check(n < 80, 1'b1);
      if (n >= 80) begin
         finish_test();
      end
      check(n >= min_cyc, 1'b1);
      check(pc_value, RSC_PC_RST);
      check(clkcfg, {RSC_CLK_LPOSC, 1'b1, RSC_WDT_CLK_LFO});
      @(negedge clk);
      check(ctrl, 5'h00);
      check({drive_low, pins.weak_pullup_en}, 2'h1);
      check({regulator_on, core_power_on, osc_run, periph_clk_en}, 4'hF);
   endtask : wait_run

   // ==========================================
   // scenarios
   // src bits: button, power-on, supply monitor, internal
   task automatic t_source(input logic [3:0] src, input logic drv, input logic poc);
      {press_pin, trip_por, trip_mon, other_reset} = src;
      repeat (6) @(negedge clk);
      chk_reset(drv, poc);
      {press_pin, trip_por, trip_mon, other_reset} = 4'h0;
      wait_run(20);
   endtask : t_source

   // stop (flag low) or shutdown (flag high), then the wake
   task automatic t_lowpower(input logic flag, input logic by_por);
      stop_config_flag = flag;
      stop_bit_set = 1'b1;
      @(negedge clk);
      // instruction not done yet: nothing may power down
      check(regulator_on, 1'b1);
      instr_done = 1'b1;
      @(negedge clk);
      stop_bit_set = 1'b0;
      instr_done = 1'b0;
      repeat (2) @(negedge clk);
      check({osc_run, periph_clk_en, ctrl.core_halt}, 3'h1);
      check({regulator_on, core_power_on}, {2{!flag}});
      if (flag) begin
         // monitor and internal resets must not wake shutdown
         {trip_mon, other_reset} = 2'h3;
         repeat (8) @(negedge clk);
         {trip_mon, other_reset} = 2'h0;
         repeat (4) @(negedge clk);
         check({regulator_on, core_power_on}, 2'h0);
         t_source({!by_por, by_por, 2'h0}, by_por, by_por);
      end else begin
         t_source(4'h1, 1'b0, 1'b0);
      end
   endtask : t_lowpower

   // ==========================================
   // main sequence: power-up, every source, stop and shutdown
   initial begin
      repeat (10) @(negedge clk);
      chk_reset(1'b1, 1'b1);
      repeat (10) @(negedge clk);
      rst = 1'b0;
      wait_run(20);
      t_source(4'h8, 1'b0, 1'b0);
      t_source(4'h4, 1'b1, 1'b1);
      t_source(4'h2, 1'b1, 1'b0);
      t_source(4'h1, 1'b0, 1'b0);
      t_lowpower(1'b0, 1'b0);
      t_lowpower(1'b1, 1'b0);
      t_lowpower(1'b1, 1'b1);
      finish_test();
   end
endmodule : reset_and_shutdown_control_bench

`default_nettype wire

// [sim/rsc_reset_source_model.sv]
// partner model: external reset button, power-on detector, supply monitor
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_source_model (
   input wire logic press_pin,         // bench holds the reset button down
   input wire logic trip_por,          // bench fakes a power-on event
   input wire logic trip_mon,          // bench fakes a supply dip
   input wire logic drive_low,         // device enable on the reset pin
   input wire logic pin_out,           // device level on the reset pin
   output logic pin_reset_n,           // button seen by the device
   output logic por_event,             // detector outputs, async levels
   output logic supply_mon_event,
   output logic pin_level              // resolved wire with its pull-up
);
   // ==========================================
   // detectors
   // the pin input is the button only: feeding the device's own pull-down
   // back would hold it in reset forever, so the wire is watched apart
   assign pin_reset_n = !press_pin;
   assign por_event = trip_por;
   assign supply_mon_event = trip_mon;
   // ==========================================
   // pin wire: pulled up, low while anyone pulls it down
   assign pin_level = !(press_pin || (drive_low && !pin_out));
endmodule : rsc_reset_source_model

`default_nettype wire
